// ### logic/abfp_pkg.sv
// Function
// - Port active only when configuration selects it
// - Transfers timed by strobe edges only
// - Data bus driven only while read low
// - Data flag low when byte waits
// - Read rising forces data flag high
// - Flags undriven while reset is active
// - Space flag low when byte accepted
// - Read falling puts head byte out
// - Read rising advances to next byte
// - Write falling captures bus byte
// - Wake pulse in suspend requests resume
// - Wake pulse when powered flushes transmit
`default_nettype none

package abfp_pkg;

    // ------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------
    // Byte width of the data bus
    localparam int DATA_W = 8;
    // Flip-flops in each pin synchroniser
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    // Byte registers clear to zero
    localparam logic [7:0] BYTE_RST = 8'h00;
    // Pins idle high (strobes and wake inactive)
    localparam logic PIN_IDLE = 1'b1;
    // Flags read inactive (high) when driven
    localparam logic FLAG_RST = 1'b1;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    // Raw pin levels sampled together
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic wake_n;
        logic [7:0] data;
    } abfp_pins_t;

    // Reset level of the pin group
    localparam abfp_pins_t PINS_RST = '{rd_n: 1'b1, wr_n: 1'b1, wake_n: 1'b1, data: 8'h00};

    // Flag pin pair: level and output enable
    typedef struct packed {
        logic level_n;
        logic oe;
    } abfp_flag_t;

    // Flag pin reset: high, undriven
    localparam abfp_flag_t FLAG_OFF = '{level_n: 1'b1, oe: 1'b0};

    // Receive head states
    typedef enum logic [1:0] {
        RX_EMPTY,
        RX_HELD,
        RX_DRIVE
    } abfp_rx_state_t;

endpackage

`default_nettype wire

// ### logic/abfp_top.sv
`timescale 1ns/100ps
`default_nettype none

module abfp_top #(
    parameter int SYNC_STAGES = abfp_pkg::SYNC_STAGES
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Configuration select for this channel
    input wire logic fifo_mode_en,
    // Remote wakeup allowed by configuration
    input wire logic remote_wake_en,
    // Link power status, low when powered (same clock)
    input wire logic powered_ok_n,
    // Strobe and wake pins
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic send_now_wake_n,
    // Bidirectional data bus as three signals
    input wire logic [7:0] chan_data_bus_in,
    output logic [7:0] chan_data_bus_out,
    output logic chan_data_bus_oe,
    // Flag pins with output enables
    output logic rx_data_avail_n,
    output logic rx_data_avail_oe,
    output logic tx_space_avail_n,
    output logic tx_space_avail_oe,
    // Receive byte feed from the engine
    input wire logic rx_in_valid,
    input wire logic [7:0] rx_in_data,
    output logic rx_in_ready,
    // Transmit byte feed to the engine
    output logic tx_out_valid,
    output logic [7:0] tx_out_data,
    input wire logic tx_out_ready,
    // Engine requests, one-cycle pulses
    output logic resume_req,
    output logic send_now_req
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Fewer than two stages cannot tame metastability
    if (SYNC_STAGES < 2)
    begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // High-to-low edge between two samples
    function automatic logic fell(input logic prev, input logic now);
        fell = prev & ~now;
    endfunction

    // Low-to-high edge between two samples
    function automatic logic rose(input logic prev, input logic now);
        rose = ~prev & now;
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    // Raw pins gathered into one group
    abfp_pkg::abfp_pins_t pins_raw;
    // Synchroniser chain, stage 0 is the first flop
    abfp_pkg::abfp_pins_t sync_ff [SYNC_STAGES];
    // Previous synchronised sample for edge finding
    abfp_pkg::abfp_pins_t prev_ff;
    // Synchronised current sample
    abfp_pkg::abfp_pins_t pins_s;
    // Edge events
    logic rd_fall;
    logic rd_rise;
    logic wr_fall;
    logic wake_fall;
    // Receive head state and byte
    abfp_pkg::abfp_rx_state_t rx_state_ff;
    logic [7:0] head_ff;
    // Receive feed handshake
    logic rx_take;
    logic rx_in_ready_ff;
    // Bus drive registers
    logic [7:0] bus_out_ff;
    logic bus_oe_ff;
    // Flag registers
    abfp_pkg::abfp_flag_t rxf_ff;
    abfp_pkg::abfp_flag_t txe_ff;
    // Transmit capture registers
    logic tx_valid_ff;
    logic [7:0] tx_data_ff;
    logic tx_accept;
    // Wake pulse registers
    logic resume_ff;
    logic send_now_ff;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign pins_raw = '{rd_n: rd_strobe_n, wr_n: wr_strobe_n,
                        wake_n: send_now_wake_n, data: chan_data_bus_in};

    // Data rides the same chain so it aligns with the write strobe
    // strobes and data synchronised together
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < SYNC_STAGES; i++)
            begin
                sync_ff[i] <= abfp_pkg::PINS_RST;
            end
        end
        else
        begin
            sync_ff[0] <= pins_raw;
            for (int i = 1; i < SYNC_STAGES; i++)
            begin
                sync_ff[i] <= sync_ff[i-1];
            end
        end
    end

    // Last stage is the clean sample
    assign pins_s = sync_ff[SYNC_STAGES-1];

    // Previous clean sample for edges
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            prev_ff <= abfp_pkg::PINS_RST;
        end
        else
        begin
            prev_ff <= pins_s;
        end
    end

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    // strobe edges time transfers
    assign rd_fall = fell(prev_ff.rd_n, pins_s.rd_n);
    assign rd_rise = rose(prev_ff.rd_n, pins_s.rd_n);
    assign wr_fall = fell(prev_ff.wr_n, pins_s.wr_n);
    assign wake_fall = fell(prev_ff.wake_n, pins_s.wake_n);

    // ------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------
    // Byte taken from the engine into the empty head
    assign rx_take = rx_in_valid & rx_in_ready_ff;

    // Head state: empty, held, or on the bus
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_state_ff <= abfp_pkg::RX_EMPTY;
        end
        else
        begin
            case (rx_state_ff)
                // Waiting for the next received byte
                abfp_pkg::RX_EMPTY:
                begin
                    if (rx_take)
                    begin
                        rx_state_ff <= abfp_pkg::RX_HELD;
                    end
                end
                // Byte waiting; read falling puts it out
                abfp_pkg::RX_HELD:
                begin
                    if (rd_fall && fifo_mode_en)
                    begin
                        rx_state_ff <= abfp_pkg::RX_DRIVE;
                    end
                end
                // On the bus until read rises
                abfp_pkg::RX_DRIVE:
                begin
                    if (rd_rise)
                    begin
                        rx_state_ff <= abfp_pkg::RX_EMPTY;
                    end
                end
                default:
                begin
                    rx_state_ff <= abfp_pkg::RX_EMPTY;
                end
            endcase
        end
    end

    // Head byte loaded when taken from the engine
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            head_ff <= abfp_pkg::BYTE_RST;
        end
        else if (rx_take)
        begin
            head_ff <= rx_in_data;
        end
    end

    // Ready only while the head is empty and not filling now
    // next byte fetched after rise
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_in_ready_ff <= 1'b0;
        end
        else
        begin
            rx_in_ready_ff <= (rx_state_ff == abfp_pkg::RX_EMPTY) && !rx_take;
        end
    end

    // Bus drive follows the read strobe
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_out_ff <= abfp_pkg::BYTE_RST;
            bus_oe_ff <= 1'b0;
        end
        else if (rx_state_ff == abfp_pkg::RX_HELD && rd_fall && fifo_mode_en)
        begin
            bus_out_ff <= head_ff;
            bus_oe_ff <= 1'b1;
        end
        else if (rd_rise || !fifo_mode_en)
        begin
            bus_oe_ff <= 1'b0;
        end
    end

    // Data-available flag and its enable
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rxf_ff <= abfp_pkg::FLAG_OFF;
        end
        else
        begin
            rxf_ff.oe <= fifo_mode_en;
            if (rx_state_ff == abfp_pkg::RX_DRIVE && rd_rise)
            begin
                rxf_ff.level_n <= abfp_pkg::FLAG_RST;
            end
            else if (rx_take)
            begin
                rxf_ff.level_n <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit side
    // ------------------------------------------------------------
    // Engine drains the captured byte
    assign tx_accept = tx_valid_ff & tx_out_ready;

    // Capture on write falling when space is flagged
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_valid_ff <= 1'b0;
            tx_data_ff <= abfp_pkg::BYTE_RST;
        end
        else if (wr_fall && fifo_mode_en && !tx_valid_ff)
        begin
            tx_valid_ff <= 1'b1;
            tx_data_ff <= pins_s.data;
        end
        else if (tx_accept)
        begin
            tx_valid_ff <= 1'b0;
        end
    end

    // Space-available flag and its enable
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            txe_ff <= abfp_pkg::FLAG_OFF;
        end
        else
        begin
            txe_ff.oe <= fifo_mode_en;
            if (wr_fall && fifo_mode_en && !tx_valid_ff)
            begin
                txe_ff.level_n <= abfp_pkg::FLAG_RST;
            end
            else
            begin
                txe_ff.level_n <= tx_valid_ff & ~tx_accept;
            end
        end
    end

    // ------------------------------------------------------------
    // Send-immediate and wake
    // ------------------------------------------------------------
    // One low pulse gives one request pulse
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            resume_ff <= 1'b0;
            send_now_ff <= 1'b0;
        end
        else
        begin
            resume_ff <= wake_fall && fifo_mode_en && powered_ok_n && remote_wake_en;
            send_now_ff <= wake_fall && fifo_mode_en && !powered_ok_n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign chan_data_bus_out = bus_out_ff;
    assign chan_data_bus_oe = bus_oe_ff;
    assign rx_data_avail_n = rxf_ff.level_n;
    assign rx_data_avail_oe = rxf_ff.oe;
    assign tx_space_avail_n = txe_ff.level_n;
    assign tx_space_avail_oe = txe_ff.oe;
    assign rx_in_ready = rx_in_ready_ff;
    assign tx_out_valid = tx_valid_ff;
    assign tx_out_data = tx_data_ff;
    assign resume_req = resume_ff;
    assign send_now_req = send_now_ff;

endmodule

`default_nettype wire

// ### testbench/abfp_top_properties.sv
`timescale 1ns/100ps
`default_nettype none

module abfp_top_properties #(
    parameter int SYNC_STAGES = 2
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic fifo_mode_en,
    input wire logic remote_wake_en,
    input wire logic powered_ok_n,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic send_now_wake_n,
    input wire logic [7:0] chan_data_bus_out,
    input wire logic chan_data_bus_oe,
    input wire logic rx_data_avail_n,
    input wire logic rx_data_avail_oe,
    input wire logic tx_space_avail_n,
    input wire logic tx_space_avail_oe,
    input wire logic rx_in_valid,
    input wire logic rx_in_ready,
    input wire logic tx_out_valid,
    input wire logic resume_req,
    input wire logic send_now_req
);
    // Everything on the design clock
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    // Read strobe falls on a flagged byte
    sequence s_read_fall;
        $fell(rd_strobe_n) && !rx_data_avail_n && rx_data_avail_oe && !chan_data_bus_oe;
    endsequence
    // Bus let go and flag raised
    sequence s_released;
        !chan_data_bus_oe && rx_data_avail_n;
    endsequence

    property p_read_drive;
        s_read_fall |-> ##[1:5] chan_data_bus_oe;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("bus not driven after read");
    property p_read_end;
        $rose(rd_strobe_n) && chan_data_bus_oe |-> ##[1:5] s_released;
    endproperty
    a_read_end: assert property (p_read_end) else $error("read end not seen");
    property p_idle_off;
        rd_strobe_n [*5] |-> !chan_data_bus_oe;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("bus driven with read high");
    property p_drive_cause;
        $rose(chan_data_bus_oe) |-> !$past(rd_strobe_n, 2);
    endproperty
    a_drive_cause: assert property (p_drive_cause) else $error("bus driven without strobe");
    property p_hold_byte;
        chan_data_bus_oe && $past(chan_data_bus_oe) |-> $stable(chan_data_bus_out);
    endproperty
    a_hold_byte: assert property (p_hold_byte) else $error("driven byte changed");
    property p_reset_quiet;
        disable iff (1'b0) !resetn |-> !rx_data_avail_oe && !tx_space_avail_oe;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("flag driven in reset");
    property p_mode_off;
        !fifo_mode_en [*3] |-> !rx_data_avail_oe && !tx_space_avail_oe && !chan_data_bus_oe;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("port active while off");
    property p_rx_flag;
        rx_in_valid && rx_in_ready && rx_data_avail_oe |=> !rx_data_avail_n;
    endproperty
    a_rx_flag: assert property (p_rx_flag) else $error("byte waits, flag high");
    property p_write;
        $fell(wr_strobe_n) && !tx_space_avail_n && tx_space_avail_oe && !tx_out_valid
            |-> ##[1:6] (tx_out_valid && tx_space_avail_n);
    endproperty
    a_write: assert property (p_write) else $error("write not captured");
    property p_send_now;
        $fell(send_now_wake_n) && fifo_mode_en && !powered_ok_n |-> ##[1:6] send_now_req;
    endproperty
    a_send_now: assert property (p_send_now) else $error("no send request");
    property p_resume;
        $fell(send_now_wake_n) && fifo_mode_en && powered_ok_n && remote_wake_en
            |-> ##[1:6] resume_req;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume request");
endmodule

`default_nettype wire

// ### testbench/abfp_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module abfp_host_model (
    input wire logic clk,
    input wire logic [7:0] dev_out,
    input wire logic dev_oe,
    input wire logic rx_avail_n,
    input wire logic tx_space_n,
    output logic rd_n,
    output logic wr_n,
    output logic wake_n,
    output logic [7:0] bus_level
);
    logic [7:0] host_d;
    logic host_en;
    logic [7:0] last_ff;

    initial
    begin
        rd_n = 1'b1;
        wr_n = 1'b1;
        wake_n = 1'b1;
        host_d = 8'h00;
        host_en = 1'b0;
        last_ff = 8'h00;
    end

    // Floating bus shows inverse of last driven level
    assign bus_level = dev_oe ? dev_out : (host_en ? host_d : ~last_ff);
    // Remember the level only while someone drives the bus
    always @(posedge clk)
    begin
        if (dev_oe || host_en)
        begin
            last_ff <= bus_level;
        end
    end

    // Read one byte; ok low on timeout
    task automatic rd_byte(output logic [7:0] d, output bit ok);
        int n;
        ok = 1'b0;
        d = 8'h00;
        for (n = 0; n < 60; n++)
        begin
            @(negedge clk);
            if (rx_avail_n === 1'b0) break;
        end
        if (n == 60) return;
        @(posedge clk);
        host_en <= 1'b0;
        rd_n <= 1'b0;
        for (n = 0; n < 10 && dev_oe !== 1'b1; n++) @(negedge clk);
        d = bus_level;
        ok = (n < 10);
        @(posedge clk);
        rd_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    // Write one byte around a strobe fall
    task automatic wr_byte(input logic [7:0] b, output bit ok);
        int n;
        for (n = 0; n < 60 && tx_space_n !== 1'b0; n++) @(negedge clk);
        ok = (n < 60);
        // strobe high then low on space
        @(posedge clk);
        host_en <= 1'b1;
        host_d <= b;
        repeat (3) @(posedge clk);
        wr_n <= 1'b0;
        repeat (3) @(posedge clk);
        wr_n <= 1'b1;
        host_en <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // Short low pulse on the wake pin
    task automatic wake_pulse();
        @(posedge clk);
        wake_n <= 1'b0;
        repeat (3) @(posedge clk);
        wake_n <= 1'b1;
    endtask
endmodule

`default_nettype wire

// ### testbench/abfp_top_bench.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) \
begin \
    tests_run++; \
    if ((a) !== (b)) \
    begin \
        err_total++; \
        $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); \
    end \
end

bind abfp_top abfp_top_properties #(.SYNC_STAGES(SYNC_STAGES)) abfp_top_properties_i (
    .mclk, .resetn, .fifo_mode_en, .remote_wake_en, .powered_ok_n, .rd_strobe_n,
    .wr_strobe_n, .send_now_wake_n, .chan_data_bus_out, .chan_data_bus_oe, .rx_data_avail_n,
    .rx_data_avail_oe, .tx_space_avail_n, .tx_space_avail_oe, .rx_in_valid, .rx_in_ready,
    .tx_out_valid, .resume_req, .send_now_req
);

module abfp_top_bench;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic fifo_mode_en = 1'b1;
    logic remote_wake_en = 1'b0;
    logic powered_ok_n = 1'b0;
    logic rx_in_valid = 1'b0;
    logic tx_out_ready = 1'b0;
    logic [7:0] rx_in_data = 8'h00;
    logic rd_strobe_n, wr_strobe_n, send_now_wake_n, chan_data_bus_oe, rx_in_ready;
    logic rx_data_avail_n, rx_data_avail_oe, tx_space_avail_n, tx_space_avail_oe;
    logic tx_out_valid, resume_req, send_now_req;
    logic [7:0] chan_data_bus_in, chan_data_bus_out, tx_out_data;
    int err_total = 0;
    int tests_run = 0;
    // Flags are pulled up while undriven
    wire logic rx_pin = rx_data_avail_oe ? rx_data_avail_n : 1'b1;
    wire logic tx_pin = tx_space_avail_oe ? tx_space_avail_n : 1'b1;

    always #25 mclk = ~mclk;

    abfp_top abfp_top_i (
        .mclk, .resetn, .fifo_mode_en, .remote_wake_en, .powered_ok_n, .rd_strobe_n,
        .wr_strobe_n, .send_now_wake_n, .chan_data_bus_in, .chan_data_bus_out,
        .chan_data_bus_oe, .rx_data_avail_n, .rx_data_avail_oe, .tx_space_avail_n,
        .tx_space_avail_oe, .rx_in_valid, .rx_in_data, .rx_in_ready, .tx_out_valid,
        .tx_out_data, .tx_out_ready, .resume_req, .send_now_req
    );

    abfp_host_model abfp_host_model_i (
        .clk(mclk), .dev_out(chan_data_bus_out), .dev_oe(chan_data_bus_oe),
        .rx_avail_n(rx_pin), .tx_space_n(tx_pin), .rd_n(rd_strobe_n), .wr_n(wr_strobe_n),
        .wake_n(send_now_wake_n), .bus_level(chan_data_bus_in)
    );

    // Verdict and stop
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // A wait ran out
    task automatic lost();
        `CHK(1'b0, 1'b1)
        end_of_test();
    endtask

    // Reset for 10 cycles, check flags
    task automatic do_reset();
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (10) @(posedge mclk);
        `CHK({rx_data_avail_oe, tx_space_avail_oe}, 2'h0)
        resetn <= 1'b1;
        repeat (4) @(negedge mclk);
        `CHK({rx_data_avail_oe, rx_data_avail_n, tx_space_avail_oe, tx_space_avail_n},
             4'hE)
    endtask

    // Engine offers one received byte
    task automatic push(input logic [7:0] b);
        int n;
        for (n = 0; n < 60; n++)
        begin
            @(negedge mclk);
            if (rx_in_ready === 1'b1) break;
        end
        if (n == 60) lost();
        @(posedge mclk);
        rx_in_valid <= 1'b1;
        rx_in_data <= b;
        @(posedge mclk);
        rx_in_valid <= 1'b0;
        // Byte taken: ready drops, flag goes low
        @(negedge mclk);
        `CHK({rx_in_ready, rx_data_avail_n}, 2'h0)
    endtask

    // Host read with expected byte
    task automatic rd_chk(input logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        abfp_host_model_i.rd_byte(d, ok);
        if (!ok) lost();
        `CHK(d, exp)
    endtask

    // Back-to-back reads, next byte queued
    task automatic t_read();
        push(8'hA5);
        fork
            push(8'h3C);
            rd_chk(8'hA5);
        join
        rd_chk(8'h3C);
        // Look away from the launching edge
        @(negedge mclk);
        `CHK({chan_data_bus_oe, rx_data_avail_n}, 2'h1)
    endtask

    // Write with engine stalled, then drained
    task automatic t_write();
        int n;
        bit ok;
        @(posedge mclk);
        tx_out_ready <= 1'b0;
        abfp_host_model_i.wr_byte(8'hC3, ok);
        if (!ok) lost();
        repeat (4) @(negedge mclk);
        `CHK({tx_out_valid, tx_space_avail_n, tx_out_data}, 10'h3C3)
        @(posedge mclk);
        tx_out_ready <= 1'b1;
        for (n = 0; n < 10 && tx_space_avail_n !== 1'b0; n++) @(negedge mclk);
        `CHK({tx_out_valid, tx_space_avail_n}, 2'h0)
    endtask

    // Watch both engine requests for a while
    task automatic watch(output logic now_seen, output logic res_seen);
        now_seen = 1'b0;
        res_seen = 1'b0;
        repeat (10)
        begin
            @(negedge mclk);
            now_seen = now_seen | send_now_req;
            res_seen = res_seen | resume_req;
        end
    endtask

    // Wake pin powered, then unpowered with wake enabled and disabled
    task automatic t_wake();
        logic a, b;
        abfp_host_model_i.wake_pulse();
        watch(a, b);
        `CHK({a, b}, 2'h2)
        @(posedge mclk);
        powered_ok_n <= 1'b1;
        remote_wake_en <= 1'b1;
        abfp_host_model_i.wake_pulse();
        watch(a, b);
        `CHK({a, b}, 2'h1)
        @(posedge mclk);
        remote_wake_en <= 1'b0;
        abfp_host_model_i.wake_pulse();
        watch(a, b);
        `CHK({a, b}, 2'h0)
        @(posedge mclk);
        powered_ok_n <= 1'b0;
    endtask

    // Port off: flags and bus released
    task automatic t_mode_off();
        @(posedge mclk);
        fifo_mode_en <= 1'b0;
        repeat (4) @(negedge mclk);
        `CHK({rx_data_avail_oe, tx_space_avail_oe, chan_data_bus_oe}, 3'h0)
        @(posedge mclk);
        fifo_mode_en <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    // Main sequence
    initial
    begin
        do_reset();
        t_read();
        t_write();
        t_wake();
        t_mode_off();
        do_reset();
        t_read();
        end_of_test();
    end
endmodule

`default_nettype wire
